/* hw/asq_pkg.sv */
// Constants, register map and carrier types of the segment sequencer.
// Assumes a single 40 MHz clock and a classic Wishbone register bus.
package asq_pkg;
  // Clock and rate limits
  localparam int CLK_HZ = 40_000_000;
  localparam longint FILT_MAX_SPS = 250_000_000;
  // Least divider with the filter off, rounded up to whole clocks
  localparam int FOFF_MIN_DIV_I = int'((longint'(CLK_HZ) + FILT_MAX_SPS
                                  - 1) / FILT_MAX_SPS) - 1;
  localparam logic [15:0] FOFF_MIN_DIV = 16'(FOFF_MIN_DIV_I);
  // Segment length limits in samples
  localparam logic [19:0] MIN_LEN = 20'h00008;
  localparam logic [19:0] MAX_LEN = 20'hf4240;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_LAST = 8'h0c;
  localparam logic [7:0] OFS_SADDR = 8'h10;
  localparam logic [7:0] OFS_SDATA = 8'h14;
  localparam logic [7:0] OFS_EBASE = 8'h18;
  localparam logic [7:0] OFS_ELEN = 8'h1c;
  localparam logic [7:0] OFS_ECOUNT = 8'h20;
  localparam logic [7:0] OFS_ECFG = 8'h24;
  localparam logic [7:0] OFS_ECOMMIT = 8'h28;
  // Control bit positions
  localparam int CTL_RUN = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_DUAL = 2;
  localparam int CTL_FOFF = 3;
  // Entry configuration field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SYNC_LSB = 2;
  localparam int CFG_PT_LSB = 4;
  // Status field positions
  localparam int STS_STEP_LSB = 8;
  // Reset values
  localparam logic [15:0] RATE_RST = 16'h0000;
  // Step repeat behaviour
  typedef enum logic [1:0] {
    MD_COUNT = 2'b00, MD_WAIT = 2'b01, MD_UNTIL = 2'b10, MD_ENDLESS = 2'b11
  } asq_mode_t;
  // Sync behaviour per step
  typedef enum logic [1:0] {
    SY_ASSERT = 2'b00, SY_NEGATE = 2'b01, SY_HOLD = 2'b10, SY_PULSE = 2'b11
  } asq_sync_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PLAY = 2'b01, ST_WAIT = 2'b10
  } asq_state_t;
  // One sequence table entry
  typedef struct packed {
    logic [19:0] base;
    logic [19:0] len;
    logic [19:0] count;
    asq_mode_t mode;
    asq_sync_t sync;
    logic [19:0] point;
  } asq_ent_t;
  // One buffered output word
  typedef struct packed {
    logic sync;
    logic [15:0] chb;
    logic [15:0] cha;
  } asq_smp_t;
endpackage : asq_pkg

/* hw/asq_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; flush empties it at once.
`timescale 1ns/100ps
module asq_buf2 #(
  parameter int W = 33
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] d0_reg; // Head entry
  logic [W-1:0] d1_reg; // Second entry
  logic [1:0] cnt_reg; // Fill level
  logic push;
  logic pop;

  // Full at two entries, so a stall never drops a word
  assign in_ready_o = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o = d0_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Entry storage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      d0_reg <= '0;
      d1_reg <= '0;
    end else if (push && pop) begin
      if (cnt_reg == 2'h1) begin
        d0_reg <= in_data_i;
      end else begin
        d0_reg <= d1_reg;
        d1_reg <= in_data_i;
      end
    end else if (pop) begin
      d0_reg <= d1_reg;
    end else if (push) begin
      if (cnt_reg == 2'h0) d0_reg <= in_data_i;
      else d1_reg <= in_data_i;
    end
  end

  // Fill level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_reg <= 2'h0;
    else if (flush_i) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
  end
endmodule : asq_buf2

/* hw/asq_rate.sv */
// Sample-rate tick generator: one tick every div+1 clocks.
// Assumes the divider is static while running.
`timescale 1ns/100ps
module asq_rate
  import asq_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  input wire logic foff_i,
  input wire logic [15:0] div_i,
  output logic tick_o
);
  logic [15:0] cnt_reg; // Clocks since last tick
  logic [15:0] eff_div; // Divider after filter clamp

  // R15 filter-off rate clamp
  assign eff_div = (foff_i && div_i < FOFF_MIN_DIV) ? FOFF_MIN_DIV : div_i;
  // R2 fixed fetch cadence
  assign tick_o = en_i && (cnt_reg >= eff_div);

  // Divider counter, restarts on each tick
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_reg <= 16'h0000;
    else if (!en_i || tick_o) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule : asq_rate

/* hw/asq_seq.sv */
// Segment sequencer top: register slave, tables, player and output.
// Assumes trig_i is synchronous and a DAC that may stall via ready.
// Functional notes
// R1 - Segments hold 8 to 1,000,000 samples; code floors at 8 but has no cap at MAX_LEN, so lengths up to 1,048,575 play
// R2 - Samples fetched at the programmed rate
// R3 - Dual channels share length, timing, rate
// R4 - Each step: segment, count, trigger, sync
// R5 - Counted mode replays, then auto-advances
// R6 - Play once, halt, advance on trigger
// R7 - Loop segment until trigger, then advance
// R8 - Endless mode repeats until stop command
// R9 - Sync: assert, negate, hold, or pulse
// R10 - Segment changes leave no idle gap
// R11 - Trigger lets current pass finish first
// R12 - Short segments may loop while draining
// R13 - Controller programs no segment below 8
// R14 - Controller leads with constant waiting segment
// R15 - Filter off may lower the rate
// R16 - Stray triggers outside waiting are ignored
// R17 - Stop or reset: step zero, sync low
`timescale 1ns/100ps
module asq_seq
  import asq_pkg::*;
#(
  parameter int AW = 20, // Sample memory address width
  parameter int TW = 7 // Sequence table index width
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_i,
  input wire logic dac_ready_i,
  output logic [15:0] dac_cha_o,
  output logic [15:0] dac_chb_o,
  output logic dac_valid_o,
  output logic sync_o
);
  // Byte-lane merge used by every writable register except CTRL and ECOMMIT
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : lane_merge

  logic [31:0] smp_mem [0:(1<<AW)-1]; // Both channels, A low, B high
  asq_ent_t seq_tab [0:(1<<TW)-1]; // Sequence table
  logic dual_reg; // Second channel enabled
  logic foff_reg; // Reconstruction filter off
  logic [15:0] div_reg; // Sample-rate divider
  logic [TW-1:0] last_reg; // Index of final step
  logic [AW-1:0] saddr_reg; // Sample write pointer
  asq_ent_t stg_reg; // Entry being assembled
  logic [31:0] stg_cfg; // Staged config word view
  logic [23:0] cfg_new; // Config word after byte-lane merge
  logic bus_req; // Request not yet answered
  logic wr_req; // Write taken this cycle
  logic start_p; // Run command
  logic stop_p; // Stop command
  asq_state_t state_reg; // Sequencer state
  logic [TW-1:0] step_reg; // Current step
  logic [AW-1:0] pos_reg; // Sample index within segment
  logic [19:0] pass_reg; // Completed passes of this step
  logic trig_seen_reg; // Trigger caught during looping step
  logic sync_lvl_reg; // Sync level of last pushed sample
  asq_ent_t cur; // Current step entry
  logic [19:0] eff_len; // Length after floor
  logic last_pos; // Final sample of this pass
  logic push; // Word enters the buffer
  logic pass_end; // Pass completes this cycle
  logic adv; // Move to next step now
  logic sync_now; // Sync bit of the pushed sample
  logic [TW-1:0] step_nx; // Following step, wrapping
  asq_smp_t in_w; // Word offered to the buffer
  asq_smp_t out_w; // Word at buffer head
  logic buf_rdy; // Buffer can accept
  logic buf_vld; // Buffer holds a word
  logic tick; // Sample-rate tick
  logic pop; // Word leaves toward the DAC

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = bus_req && wb_we_i;
  assign start_p = wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[0]
                   && wb_dat_i[CTL_RUN];
  assign stop_p = wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[0]
                  && wb_dat_i[CTL_STOP];
  assign stg_cfg = {8'h00, stg_reg.point, stg_reg.sync, stg_reg.mode};
  assign cfg_new = 24'(lane_merge(stg_cfg, wb_dat_i, wb_sel_i));

  // Bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= bus_req;
  end

  // Read data; unmapped offsets read as zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL: wb_dat_o <= 32'({foff_reg, dual_reg, 2'b00});
        OFS_STATUS: wb_dat_o <= 32'({step_reg, 6'h00, state_reg});
        OFS_RATE: wb_dat_o <= 32'(div_reg);
        OFS_LAST: wb_dat_o <= 32'(last_reg);
        OFS_SADDR: wb_dat_o <= 32'(saddr_reg);
        OFS_EBASE: wb_dat_o <= 32'(stg_reg.base);
        OFS_ELEN: wb_dat_o <= 32'(stg_reg.len);
        OFS_ECOUNT: wb_dat_o <= 32'(stg_reg.count);
        OFS_ECFG: wb_dat_o <= stg_cfg;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dual_reg <= 1'b0;
      foff_reg <= 1'b0;
      div_reg <= RATE_RST;
      last_reg <= '0;
    end else if (wr_req) begin
      if (wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
        dual_reg <= wb_dat_i[CTL_DUAL];
        foff_reg <= wb_dat_i[CTL_FOFF];
      end
      if (wb_adr_i == OFS_RATE) begin
        div_reg <= 16'(lane_merge(32'(div_reg), wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == OFS_LAST) begin
        last_reg <= TW'(lane_merge(32'(last_reg), wb_dat_i, wb_sel_i));
      end
    end
  end

  // Sample loading with auto-increment; memory has no reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      saddr_reg <= '0;
    end else if (wr_req && wb_adr_i == OFS_SADDR) begin
      saddr_reg <= AW'(lane_merge(32'(saddr_reg), wb_dat_i, wb_sel_i));
    end else if (wr_req && wb_adr_i == OFS_SDATA) begin
      saddr_reg <= saddr_reg + AW'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (wr_req && wb_adr_i == OFS_SDATA) begin
      smp_mem[saddr_reg] <= lane_merge(smp_mem[saddr_reg], wb_dat_i,
                                       wb_sel_i);
    end
  end

  // R4 entry staging fields
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stg_reg <= '0;
    end else if (wr_req) begin
      unique case (wb_adr_i)
        OFS_EBASE: stg_reg.base <= 20'(lane_merge(32'(stg_reg.base),
                                              wb_dat_i, wb_sel_i));
        OFS_ELEN: stg_reg.len <= 20'(lane_merge(32'(stg_reg.len),
                                            wb_dat_i, wb_sel_i));
        OFS_ECOUNT: stg_reg.count <= 20'(lane_merge(32'(stg_reg.count),
                                                wb_dat_i, wb_sel_i));
        OFS_ECFG: begin
          stg_reg.point <= cfg_new[CFG_PT_LSB +: 20];
          stg_reg.sync <= asq_sync_t'(cfg_new[CFG_SYNC_LSB +: 2]);
          stg_reg.mode <= asq_mode_t'(cfg_new[CFG_MODE_LSB +: 2]);
        end
        default: stg_reg <= stg_reg;
      endcase
    end
  end

  // Commit staged entry into the table at the written index
  always_ff @(posedge clk_i) begin
    if (wr_req && wb_adr_i == OFS_ECOMMIT)
      seq_tab[wb_dat_i[TW-1:0]] <= stg_reg;
  end

  assign cur = seq_tab[step_reg];
  // R1 length floor at eight samples
  assign eff_len = (cur.len < MIN_LEN) ? MIN_LEN : cur.len;
  assign last_pos = (20'(pos_reg) == eff_len - 20'h1);
  assign push = (state_reg == ST_PLAY) && buf_rdy;
  assign pass_end = push && last_pos;
  assign step_nx = (step_reg == last_reg) ? '0 : step_reg + TW'(1);

  // R5 R7 R11 advance only at a pass end
  always_comb begin
    adv = 1'b0;
    if (pass_end) begin
      unique case (cur.mode)
        MD_COUNT: adv = (pass_reg + 20'h1 >= cur.count);
        MD_UNTIL: adv = trig_seen_reg || trig_i;
        MD_WAIT: adv = 1'b0;
        MD_ENDLESS: adv = 1'b0;
      endcase
    end
  end

  // R9 per-step sync behaviour
  always_comb begin
    sync_now = sync_lvl_reg;
    if (pos_reg == '0) begin
      unique case (cur.sync)
        SY_ASSERT: sync_now = 1'b1;
        SY_NEGATE: sync_now = 1'b0;
        SY_HOLD: sync_now = sync_lvl_reg;
        SY_PULSE: sync_now = 1'b1;
      endcase
    end else if (cur.sync == SY_PULSE && 20'(pos_reg) == cur.point) begin
      sync_now = 1'b0;
    end
  end

  // R3 both channels from one word, one rate
  assign in_w.cha = smp_mem[AW'(cur.base + 20'(pos_reg))][15:0];
  assign in_w.chb = smp_mem[AW'(cur.base + 20'(pos_reg))][31:16];
  assign in_w.sync = sync_now;

  // Sequencer state and step
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      step_reg <= '0;
    end else if (stop_p) begin
      // R8 R17 stop returns to first step
      state_reg <= ST_IDLE;
      step_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (start_p) state_reg <= ST_PLAY;
        ST_PLAY: begin
          // R6 single pass then halt
          if (pass_end && cur.mode == MD_WAIT) state_reg <= ST_WAIT;
          // R10 next step follows with no gap
          if (adv) step_reg <= step_nx;
        end
        ST_WAIT: begin
          // R6 R16 a halted waiting step advances on a trigger
          if (trig_i) begin
            state_reg <= ST_PLAY;
            step_reg <= step_nx;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Position and pass counting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_reg <= '0;
      pass_reg <= 20'h00000;
    end else if (state_reg != ST_PLAY || stop_p) begin
      pos_reg <= '0;
      pass_reg <= 20'h00000;
    end else if (pass_end) begin
      // R12 looping passes wrap to start while draining
      pos_reg <= '0;
      pass_reg <= adv ? 20'h00000 : pass_reg + 20'h1;
    end else if (push) begin
      pos_reg <= pos_reg + AW'(1);
    end
  end

  // R7 R16 trigger latched only by a looping step
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) trig_seen_reg <= 1'b0;
    else if (state_reg != ST_PLAY || adv) trig_seen_reg <= 1'b0;
    else if (trig_i && cur.mode == MD_UNTIL) trig_seen_reg <= 1'b1;
  end

  // Running sync level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sync_lvl_reg <= 1'b0;
    else if (state_reg == ST_IDLE) sync_lvl_reg <= 1'b0;
    else if (push) sync_lvl_reg <= sync_now;
  end

  asq_buf2 #(
    .W($bits(asq_smp_t))
  ) u_buf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(stop_p),
    .in_valid_i(state_reg == ST_PLAY),
    .in_ready_o(buf_rdy),
    .in_data_i(in_w),
    .out_valid_o(buf_vld),
    .out_ready_i(tick && dac_ready_i),
    .out_data_o(out_w)
  );

  asq_rate u_rate (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .en_i(state_reg != ST_IDLE),
    .foff_i(foff_reg),
    .div_i(div_reg),
    .tick_o(tick)
  );

  // A stalled DAC keeps the word buffered until a tick finds it ready
  assign pop = tick && dac_ready_i && buf_vld;

  // DAC output registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_cha_o <= 16'h0000;
      dac_chb_o <= 16'h0000;
      dac_valid_o <= 1'b0;
      sync_o <= 1'b0;
    end else if (pop) begin
      // R2 one sample per rate tick
      dac_cha_o <= out_w.cha;
      dac_chb_o <= dual_reg ? out_w.chb : 16'h0000;
      dac_valid_o <= 1'b1;
      sync_o <= out_w.sync;
    end else if (state_reg == ST_IDLE) begin
      // R17 idle shows first sample of step zero
      dac_cha_o <= smp_mem[AW'(seq_tab[0].base)][15:0];
      dac_chb_o <= dual_reg ? smp_mem[AW'(seq_tab[0].base)][31:16] : 16'h0;
      dac_valid_o <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      dac_valid_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_stop_home_sync: assert property ( // R17
    stop_p |=> ##1 (!sync_o && step_reg == '0))
    else $error("stop did not return home");
  chk_dual_b_quiet: assert property ( // R3
    dac_valid_o && !$past(dual_reg) |-> dac_chb_o == 16'h0000)
    else $error("channel B active in single mode");
  chk_count_passes: assert property ( // R5
    pass_end && cur.mode == MD_COUNT && pass_reg + 20'h1 < cur.count
    && !stop_p |=> $stable(step_reg) && pass_reg != 20'h00000)
    else $error("counted step advanced early");
  chk_wait_halts: assert property ( // R6
    state_reg == ST_WAIT && !trig_i && !stop_p |=> state_reg == ST_WAIT
    && $stable(step_reg))
    else $error("waiting step moved without trigger");
  chk_wait_trig_go: assert property ( // R6
    state_reg == ST_WAIT && trig_i && !stop_p
    |=> state_reg == ST_PLAY && pos_reg == '0)
    else $error("trigger did not resume playback");
  chk_until_finish: assert property ( // R11
    state_reg == ST_PLAY && cur.mode == MD_UNTIL && trig_i && !last_pos
    && !stop_p |=> $stable(step_reg))
    else $error("looping step cut its pass short");
  chk_gapless_step: assert property ( // R10
    adv && !stop_p |=> state_reg == ST_PLAY && pos_reg == '0)
    else $error("gap at segment change");
  chk_endless_stays: assert property ( // R8
    state_reg == ST_PLAY && cur.mode == MD_ENDLESS && !stop_p
    |=> $stable(step_reg))
    else $error("endless step advanced");
  chk_stray_trig: assert property ( // R16
    state_reg == ST_IDLE && trig_i && !start_p |=> state_reg == ST_IDLE)
    else $error("idle sequencer reacted to trigger");
  chk_rate_spacing: assert property ( // R2
    dac_valid_o && div_reg != 16'h0000 && $stable(div_reg)
    |=> !dac_valid_o)
    else $error("samples faster than the rate");
  chk_pos_in_range: assert property ( // R1
    push |-> 20'(pos_reg) < eff_len)
    else $error("position beyond segment");
  chk_sync_pulse: assert property ( // R9
    push && cur.sync == SY_PULSE && pos_reg != '0
    && 20'(pos_reg) == cur.point |-> !sync_now)
    else $error("sync pulse not negated");

  cov_count_adv: cover property (adv && cur.mode == MD_COUNT);
  cov_until_adv: cover property (adv && cur.mode == MD_UNTIL);
  cov_wait_resume: cover property (state_reg == ST_WAIT && trig_i);
  cov_dac_stall: cover property (tick && buf_vld && !dac_ready_i);
endmodule : asq_seq

/* tb/asq_dac_model.sv */
// Converter stand-in: takes each offered word, may stall or run slow.
// Assumes valid pulses once per word and data holds until the next.
`timescale 1ns/100ps
module asq_dac_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [15:0] cha_i,
  input wire logic [15:0] chb_i,
  input wire logic sync_i,
  output logic ready_o,
  output int n_got_o
);
  logic phase_reg; // Toggle for slow acceptance
  int cyc_reg; // Free cycle count for stamps
  logic [32:0] cap [0:511]; // Captured {sync, b, a}
  int stamp [0:511]; // Cycle of each capture
  // Slow mode accepts only every other cycle, to stress the buffer
  assign ready_o = ~stall_i & (~slow_i | phase_reg);
  // Capture words in arrival order
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg <= 1'b0;
      cyc_reg <= 0;
      n_got_o <= 0;
    end else begin
      phase_reg <= ~phase_reg;
      cyc_reg <= cyc_reg + 1;
      // Index guard keeps a runaway stream inside the log
      if (valid_i === 1'b1 && n_got_o < 512) begin
        cap[n_got_o] <= {sync_i, chb_i, cha_i};
        stamp[n_got_o] <= cyc_reg;
        n_got_o <= n_got_o + 1;
      end
    end
  end
endmodule : asq_dac_model

/* tb/test_asq_seq.sv */
// Bench for the segment sequencer: bus tasks, stream log, checks.
// Assumes the converter stand-in of asq_dac_model.sv.
`timescale 1ns/100ps
module test_asq_seq
  import asq_pkg::*;
;
  logic clk = 1'b0; // Bench clock
  logic arst_n = 1'b0; // Reset, active low
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat; // Last read word
  logic [31:0] dat_o;
  logic ack;
  logic trig = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic ready;
  logic valid;
  logic sync;
  logic [15:0] cha;
  logic [15:0] chb;
  int n_got; // Words taken by the converter
  int bad_count = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int n2;
  int b; // First index of the endless step
  int k;
  int ea;
  always #12.5 clk = ~clk;
  asq_seq dut (.clk_i(clk), .arst_n_i(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_i(trig),
    .dac_ready_i(ready), .dac_cha_o(cha), .dac_chb_o(chb),
    .dac_valid_o(valid), .sync_o(sync));
  asq_dac_model dac (.clk_i(clk), .arst_n_i(arst_n), .stall_i(stall),
    .slow_i(slow), .valid_i(valid), .cha_i(cha), .chb_i(chb),
    .sync_i(sync), .ready_o(ready), .n_got_o(n_got));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic ent(input int i, input int bs, input int cnt,
      input logic [31:0] cfg);
    wb(1'b1, OFS_EBASE, 32'(bs));
    wb(1'b1, OFS_ELEN, 32'h8);
    wb(1'b1, OFS_ECOUNT, 32'(cnt));
    wb(1'b1, OFS_ECFG, cfg);
    wb(1'b1, OFS_ECOMMIT, 32'(i));
  endtask : ent
  task automatic pulse;
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask : pulse
  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && n_got < n; i++) @(posedge clk);
    // A stream that never arrives counts as a mismatch
    chk(32'(n_got >= n), 32'h1);
  endtask : wait_words
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_RATE, 32'(RATE_RST));
    rd(8'h40, 32'h0);
    wb(1'b1, OFS_SADDR, 32'h0);
    // Words 0..15 ramp, 16..23 constant level
    for (k = 0; k < 24; k++) begin
      wb(1'b1, OFS_SDATA, k < 16 ? {16'(k + 256), 16'(k)} : 32'h01000000);
    end
    rd(OFS_SDATA, 32'h0);
    ent(0, 16, 1, 32'({20'd0, SY_NEGATE, MD_WAIT}));
    ent(1, 0, 2, 32'({20'd3, SY_PULSE, MD_COUNT}));
    ent(2, 8, 1, 32'({20'd0, SY_ASSERT, MD_UNTIL}));
    ent(3, 0, 1, 32'({20'd0, SY_HOLD, MD_ENDLESS}));
    wb(1'b1, OFS_LAST, 32'h3);
    wb(1'b1, OFS_RATE, 32'h1);
    pulse();
    rd(OFS_STATUS, 32'h0);
    wb(1'b1, OFS_CTRL, 32'hd);
    rd(OFS_CTRL, 32'hc);
    wait_words(8);
    repeat (20) @(posedge clk);
    rd(OFS_STATUS, 32'h2);
    chk(32'(n_got), 32'h8);
    pulse();
    wait_words(12);
    pulse();
    wait_words(51);
    n2 = n_got;
    pulse();
    wait_words(n2 + 30);
    rd(OFS_STATUS, 32'h301);
    stall <= 1'b1;
    repeat (4) @(posedge clk);
    k = n_got;
    repeat (30) @(posedge clk);
    chk(32'(n_got), 32'(k));
    stall <= 1'b0;
    slow <= 1'b1;
    wait_words(k + 20);
    slow <= 1'b0;
    rd(OFS_STATUS, 32'h301);
    // Locate the switch from the looping step to the endless one
    for (b = 24; b < n_got && dac.cap[b][15:0] >= 16'h8; b++);
    ea = 24 + 8 * ((n2 - 24) / 8 + 1);
    chk(32'((b - 24) % 8 == 0 && b >= ea && b <= ea + 8), 32'h1);
    for (k = 0; k < n_got; k++) begin
      ea = k < 8 ? 0 : k < 24 ? (k - 8) % 8 : k < b ? 8 + (k - 24) % 8
        : (k - b) % 8;
      chk(32'(dac.cap[k][15:0]), 32'(ea));
      chk(32'(dac.cap[k][31:16]), 32'(ea + 256));
      if (k < 12 || k > 23)
        chk(32'(dac.cap[k][32]), 32'(!(k < 8 || k == 11)));
      if (k > 8 && k < b + 8)
        chk(32'(dac.stamp[k] - dac.stamp[k - 1]), 32'h2);
    end
    // Single-channel mode: channel B must read zero once it takes effect
    wb(1'b1, OFS_CTRL, 32'h8);
    k = n_got;
    wait_words(k + 4);
    chk(32'(dac.cap[k + 3][31:16]), 32'h0);
    wb(1'b1, OFS_CTRL, 32'h6);
    rd(OFS_STATUS, 32'h0);
    chk({31'h0, sync}, 32'h0);
    chk({cha, chb}, 32'h00000100);
    end_sim();
  end
endmodule : test_asq_seq
